// ===== jid_host.sv
module jid_host (
  // system clock, used only to pace the test clock and the trst pulse
  input wire logic mclk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // idle levels: tck stands still low between frames
  // ------------------------------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // ------------------------------------------------------------
  // one 80 ns test clock cycle
  // ------------------------------------------------------------
  // tdo is taken just before the fall, so it always holds the bit
  // launched by the previous fall; waiting for the settle is safer
  task automatic clk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(posedge mclk);
    #1 tck = 1'b1;
    repeat (4) @(posedge mclk);
    #1 o = tdo;
    tck = 1'b0;
  endtask : clk

  task automatic idle();
    logic o;
    clk(1'b0, 1'b0, o);
  endtask : idle

  // codes from bench table, serial offset port idle
  task automatic ir_load(input logic [3:0] code, output logic [3:0] cap);
    logic o;
    clk(1'b1, 1'b0, o);
    clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
    clk(1'b0, 1'b0, o);
    for (int i = 0; i < 4; i++) begin
      clk(i == 3, code[i], cap[i]);
    end
    clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
  endtask : ir_load

  task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
    clk(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], dout[i]);
    end
    clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
  endtask : dr_scan

  task automatic tms_reset();
    logic o;
    repeat (5) clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
  endtask : tms_reset

  task automatic trst_pulse();
    trst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1 trst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1 idle();
  endtask : trst_pulse
endmodule : jid_host

// ===== jid_pkg.sv
package jid_pkg;

  // ----------------------------------------------------------------
  // register sizes and identity word layout
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MAKER_W = 11;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam logic ID_FIXED_BIT0 = 1'b1;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_DEVICE_IDENTITY_WORD = 4'h2;
  localparam logic [3:0] IR_CLAMP = 4'h3;
  localparam logic [3:0] IR_HIGHZ = 4'h4;
  localparam logic [3:0] IR_OFS_RD = 4'h7;
  localparam logic [3:0] IR_OFS_WR = 4'h8;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  // low two bits must read 01 during capture-ir
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  // ----------------------------------------------------------------
  // pin synchroniser bundle {trst_n, tdi, tms, tck} and its reset value
  // ----------------------------------------------------------------
  localparam int SYNC_W = 4;
  localparam logic [3:0] SYNC_RST = 4'h2;
  localparam int SYNC_TCK = 0;
  localparam int SYNC_TMS = 1;
  localparam int SYNC_TDI = 2;
  localparam int SYNC_TRST_N = 3;

  // consecutive tms-high rising edges that force test-logic-reset
  localparam int TAP_RESET_ONES = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jid_tap_e;

  typedef enum logic [1:0] {
    PATH_BSR, PATH_ID, PATH_BYP, PATH_OFS
  } jid_path_e;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic serial;
  } jid_chain_s;

  typedef struct packed {
    logic bsr_drive;
    logic all_hiz;
    logic bsr_sel;
    logic ofs_rd;
    logic ofs_wr;
  } jid_mode_s;

  typedef struct packed {
    jid_tap_e tap;
    logic tck_prev;
    logic [3:0] ir;
    jid_path_e path;
    logic byp;
    logic tdo;
    logic tdo_oe;
    jid_chain_s chain;
    jid_mode_s mode;
  } jid_state_s;

endpackage : jid_pkg

// ===== jid_scan_reg.sv
module jid_scan_reg #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // one-cycle controls
  input wire logic capture,
  input wire logic shift,
  // data
  input wire logic [W-1:0] cap_val,
  input wire logic serial_in,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] sr;
  } jid_scan_s;

  jid_scan_s scan_reg;
  jid_scan_s scan_next;

  // lsb sits nearest tdo, new bits enter at the msb
  always_comb begin
    scan_next = scan_reg;
    if (capture) begin
      scan_next.sr = cap_val;
    end else if (shift) begin
      scan_next.sr = {serial_in, scan_reg.sr[W-1:1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scan_reg <= '{sr: RST_VAL};
    end else begin
      scan_reg <= scan_next;
    end
  end

  assign q = scan_reg.sr;

endmodule : jid_scan_reg

// ===== jid_sync3.sv
module jid_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // asynchronous in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } jid_sync_s;

  jid_sync_s sync_reg;
  jid_sync_s sync_next;

  // a bit only moves once stages two and three agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.q[i] = sync_reg.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;

endmodule : jid_sync3

// ===== jid_tap_decode.sv
module jid_tap_decode #(
  // arbitrary identity values, not those of any real part
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h5a01,
  parameter logic [10:0] ID_MAKER = 11'h07e
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // external chains: boundary cells and flag offset registers
  input wire logic bsr_so,
  input wire logic ofs_so,
  output jid_pkg::jid_chain_s chain,
  // pin and offset-port modes
  output jid_pkg::jid_mode_s mode,
  output logic [3:0] instr
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  localparam jid_pkg::jid_state_s ST_RST = '{
    tap: jid_pkg::TAP_TLR,
    tck_prev: 1'b0,
    ir: jid_pkg::IR_DEVICE_IDENTITY_WORD,
    path: jid_pkg::PATH_ID,
    byp: 1'b0,
    tdo: 1'b0,
    tdo_oe: 1'b0,
    chain: '0,
    mode: '0
  };

  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, jid_pkg::ID_FIXED_BIT0};

  jid_pkg::jid_state_s st_reg;
  jid_pkg::jid_state_s st_next;
  logic [3:0] pins_s;
  logic s_tck;
  logic s_tms;
  logic s_tdi;
  logic s_trst_n;
  logic rise;
  logic fall;
  logic ext_sel;
  logic ir_cap;
  logic ir_shift;
  logic id_cap;
  logic id_shift;
  logic dr_bit;
  logic [3:0] ir_sr;
  logic [31:0] id_sr;

  // ----------------------------------------------------------------
  // pin synchronisers and shift registers
  // ----------------------------------------------------------------
  jid_sync3 #(
    .W(jid_pkg::SYNC_W),
    .RST_VAL(jid_pkg::SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({trst_n, tdi, tms, tck}),
    .q(pins_s)
  );

  assign s_tck = pins_s[jid_pkg::SYNC_TCK];
  assign s_tms = pins_s[jid_pkg::SYNC_TMS];
  assign s_tdi = pins_s[jid_pkg::SYNC_TDI];
  assign s_trst_n = pins_s[jid_pkg::SYNC_TRST_N];

  jid_scan_reg #(
    .W(jid_pkg::IR_W),
    .RST_VAL(jid_pkg::IR_CAPTURE_VAL)
  ) u_ir (
    .mclk(mclk),
    .rst_n(rst_n),
    .capture(ir_cap),
    .shift(ir_shift),
    .cap_val(jid_pkg::IR_CAPTURE_VAL),
    .serial_in(s_tdi),
    .q(ir_sr)
  );

  // identity shifter, reloaded from constants only
  jid_scan_reg #(
    .W(jid_pkg::ID_W),
    .RST_VAL(ID_WORD)
  ) u_id (
    .mclk(mclk),
    .rst_n(rst_n),
    .capture(id_cap),
    .shift(id_shift),
    .cap_val(ID_WORD),
    .serial_in(s_tdi),
    .q(id_sr)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // path selection per instruction
  function automatic jid_pkg::jid_path_e f_path(input logic [3:0] code);
    jid_pkg::jid_path_e p;
    unique case (code)
      jid_pkg::IR_EXTEST,
      jid_pkg::IR_SAMPLE: p = jid_pkg::PATH_BSR;
      jid_pkg::IR_DEVICE_IDENTITY_WORD: p = jid_pkg::PATH_ID;
      jid_pkg::IR_OFS_RD,
      jid_pkg::IR_OFS_WR: p = jid_pkg::PATH_OFS;
      default: p = jid_pkg::PATH_BYP;
    endcase
    return p;
  endfunction : f_path

  // pin modes; sample keeps pins functional
  function automatic jid_pkg::jid_mode_s f_mode(input logic [3:0] code);
    jid_pkg::jid_mode_s m;
    m = '0;
    m.bsr_drive = (code == jid_pkg::IR_EXTEST) || (code == jid_pkg::IR_CLAMP);
    m.all_hiz = (code == jid_pkg::IR_HIGHZ);
    m.bsr_sel = (code == jid_pkg::IR_EXTEST) || (code == jid_pkg::IR_SAMPLE);
    m.ofs_rd = (code == jid_pkg::IR_OFS_RD);
    m.ofs_wr = (code == jid_pkg::IR_OFS_WR);
    return m;
  endfunction : f_mode

  function automatic jid_pkg::jid_tap_e f_tap(input jid_pkg::jid_tap_e s, input logic m);
    jid_pkg::jid_tap_e n;
    unique case (s)
      jid_pkg::TAP_TLR: n = m ? jid_pkg::TAP_TLR : jid_pkg::TAP_RTI;
      jid_pkg::TAP_RTI: n = m ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_RTI;
      jid_pkg::TAP_SEL_DR: n = m ? jid_pkg::TAP_SEL_IR : jid_pkg::TAP_CAP_DR;
      jid_pkg::TAP_CAP_DR: n = m ? jid_pkg::TAP_EXIT1_DR : jid_pkg::TAP_SHIFT_DR;
      jid_pkg::TAP_SHIFT_DR: n = m ? jid_pkg::TAP_EXIT1_DR : jid_pkg::TAP_SHIFT_DR;
      jid_pkg::TAP_EXIT1_DR: n = m ? jid_pkg::TAP_UPD_DR : jid_pkg::TAP_PAUSE_DR;
      jid_pkg::TAP_PAUSE_DR: n = m ? jid_pkg::TAP_EXIT2_DR : jid_pkg::TAP_PAUSE_DR;
      jid_pkg::TAP_EXIT2_DR: n = m ? jid_pkg::TAP_UPD_DR : jid_pkg::TAP_SHIFT_DR;
      jid_pkg::TAP_UPD_DR: n = m ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_RTI;
      jid_pkg::TAP_SEL_IR: n = m ? jid_pkg::TAP_TLR : jid_pkg::TAP_CAP_IR;
      jid_pkg::TAP_CAP_IR: n = m ? jid_pkg::TAP_EXIT1_IR : jid_pkg::TAP_SHIFT_IR;
      jid_pkg::TAP_SHIFT_IR: n = m ? jid_pkg::TAP_EXIT1_IR : jid_pkg::TAP_SHIFT_IR;
      jid_pkg::TAP_EXIT1_IR: n = m ? jid_pkg::TAP_UPD_IR : jid_pkg::TAP_PAUSE_IR;
      jid_pkg::TAP_PAUSE_IR: n = m ? jid_pkg::TAP_EXIT2_IR : jid_pkg::TAP_PAUSE_IR;
      jid_pkg::TAP_EXIT2_IR: n = m ? jid_pkg::TAP_UPD_IR : jid_pkg::TAP_SHIFT_IR;
      jid_pkg::TAP_UPD_IR: n = m ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_RTI;
    endcase
    return n;
  endfunction : f_tap

  // ----------------------------------------------------------------
  // tck edges and data-register controls
  // ----------------------------------------------------------------
  // edges are seen a few mclk late, but tms and tdi share the same delay
  assign rise = s_tck && !st_reg.tck_prev && s_trst_n;
  assign fall = !s_tck && st_reg.tck_prev && s_trst_n;
  // only a selected boundary or offset path ever sees pulses
  assign ext_sel = (st_reg.path == jid_pkg::PATH_BSR) || (st_reg.path == jid_pkg::PATH_OFS);
  assign ir_cap = rise && (st_reg.tap == jid_pkg::TAP_CAP_IR);
  assign ir_shift = rise && (st_reg.tap == jid_pkg::TAP_SHIFT_IR);
  // identity capture never touches the core
  assign id_cap = rise && (st_reg.tap == jid_pkg::TAP_CAP_DR) && (st_reg.path == jid_pkg::PATH_ID);
  assign id_shift = rise && (st_reg.tap == jid_pkg::TAP_SHIFT_DR)
                    && (st_reg.path == jid_pkg::PATH_ID);

  always_comb begin
    unique case (st_reg.path)
      jid_pkg::PATH_BSR: dr_bit = bsr_so;
      jid_pkg::PATH_ID: dr_bit = id_sr[0];
      jid_pkg::PATH_BYP: dr_bit = st_reg.byp;
      jid_pkg::PATH_OFS: dr_bit = ofs_so;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tck_prev = s_tck;
    st_next.chain.capture = 1'b0;
    st_next.chain.shift = 1'b0;
    st_next.chain.update = 1'b0;
    st_next.chain.serial = s_tdi;
    // trst forces reset; the fsm handles five tms-high edges
    if (!s_trst_n) begin
      st_next.tap = jid_pkg::TAP_TLR;
    end else if (rise) begin
      st_next.tap = f_tap(st_reg.tap, s_tms);
    end
    if (rise && ext_sel) begin
      st_next.chain.capture = (st_reg.tap == jid_pkg::TAP_CAP_DR);
      st_next.chain.shift = (st_reg.tap == jid_pkg::TAP_SHIFT_DR);
    end
    if (fall && ext_sel && (st_reg.tap == jid_pkg::TAP_UPD_DR)) begin
      st_next.chain.update = 1'b1;
    end
    if (rise && (st_reg.path == jid_pkg::PATH_BYP)) begin
      if (st_reg.tap == jid_pkg::TAP_CAP_DR) begin
        st_next.byp = 1'b0;
      end else if (st_reg.tap == jid_pkg::TAP_SHIFT_DR) begin
        st_next.byp = s_tdi;
      end
    end
    if (!s_trst_n || (st_reg.tap == jid_pkg::TAP_TLR)) begin
      st_next.ir = jid_pkg::IR_DEVICE_IDENTITY_WORD;
    // latch on falling edge in update-ir
    end else if (fall && (st_reg.tap == jid_pkg::TAP_UPD_IR)) begin
      st_next.ir = ir_sr;
    end
    // tdo changes on falling tck, driven only while shifting
    if (!s_trst_n) begin
      st_next.tdo_oe = 1'b0;
    end else if (fall) begin
      st_next.tdo_oe = 1'b0;
      if (st_reg.tap == jid_pkg::TAP_SHIFT_IR) begin
        st_next.tdo = ir_sr[0];
        st_next.tdo_oe = 1'b1;
      end else if (st_reg.tap == jid_pkg::TAP_SHIFT_DR) begin
        st_next.tdo = dr_bit;
        st_next.tdo_oe = 1'b1;
      end
    end
    // offset access modes follow the latched code
    st_next.path = f_path(st_next.ir);
    st_next.mode = f_mode(st_next.ir);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tdo = st_reg.tdo;
  assign tdo_oe = st_reg.tdo_oe;
  assign chain = st_reg.chain;
  assign mode = st_reg.mode;
  assign instr = st_reg.ir;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic [2:0] ones_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || !s_trst_n) begin
      ones_cnt <= 3'h0;
    end else if (rise) begin
      if (!s_tms) begin
        ones_cnt <= 3'h0;
      end else if (ones_cnt != 3'(jid_pkg::TAP_RESET_ONES)) begin
        ones_cnt <= ones_cnt + 3'h1;
      end
    end
  end

  sequence s_update_ir;
    fall && (st_reg.tap == jid_pkg::TAP_UPD_IR);
  endsequence

  sequence s_bypass_capture;
    rise && (st_reg.tap == jid_pkg::TAP_CAP_DR) && (st_reg.path == jid_pkg::PATH_BYP);
  endsequence

  property p_ir_latch;
    $changed(st_reg.ir) && $past(s_trst_n) && ($past(st_reg.tap) != jid_pkg::TAP_TLR)
      |-> $past(fall && (st_reg.tap == jid_pkg::TAP_UPD_IR)) && (st_reg.ir == $past(ir_sr));
  endproperty
  a_ir_latch: assert property (p_ir_latch) else $error("instruction changed off update-ir");

  property p_ir_take;
    s_update_ir |=> (st_reg.ir == $past(ir_sr)) && (st_reg.path == f_path($past(ir_sr)));
  endproperty
  a_ir_take: assert property (p_ir_take) else $error("shifted code not made current");

  property p_reset_device_identity_word;
    (st_reg.tap == jid_pkg::TAP_TLR) |=> (st_reg.ir == jid_pkg::IR_DEVICE_IDENTITY_WORD)
      && (st_reg.path == jid_pkg::PATH_ID);
  endproperty
  a_reset_device_identity_word: assert property (p_reset_device_identity_word) else $error("reset did not pick identity");

  property p_byp_zero;
    s_bypass_capture |=> !st_reg.byp;
  endproperty
  a_byp_zero: assert property (p_byp_zero) else $error("bypass did not capture zero");

  property p_ir_shift_only;
    $changed(ir_sr) |-> $past(rise) && ($past(st_reg.tap) inside {jid_pkg::TAP_SHIFT_IR,
      jid_pkg::TAP_CAP_IR});
  endproperty
  a_ir_shift_only: assert property (p_ir_shift_only) else $error("ir moved outside scan");

  property p_highz;
    (st_reg.ir == jid_pkg::IR_HIGHZ) |-> st_reg.mode.all_hiz && !st_reg.mode.bsr_drive
      && (st_reg.path == jid_pkg::PATH_BYP);
  endproperty
  a_highz: assert property (p_highz) else $error("high-z mode wrong");

  property p_clamp_quiet;
    (st_reg.ir == jid_pkg::IR_CLAMP) ##1 (st_reg.ir == jid_pkg::IR_CLAMP)
      |-> !st_reg.chain.update && !st_reg.chain.capture && st_reg.mode.bsr_drive;
  endproperty
  a_clamp_quiet: assert property (p_clamp_quiet) else $error("clamp disturbed chain");

  property p_id_capture;
    id_cap |=> (id_sr == ID_WORD) && id_sr[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identity word not loaded");

  property p_five_ones;
    (ones_cnt == 3'(jid_pkg::TAP_RESET_ONES)) |-> (st_reg.tap == jid_pkg::TAP_TLR);
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five tms-high edges no reset");

  property p_tdo_bypass;
    (fall && (st_reg.tap == jid_pkg::TAP_SHIFT_DR) && (st_reg.path == jid_pkg::PATH_BYP))
      |=> st_reg.tdo_oe && (st_reg.tdo == $past(st_reg.byp));
  endproperty
  a_tdo_bypass: assert property (p_tdo_bypass) else $error("bypass bit not on tdo");

endmodule : jid_tap_decode

// ===== tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals and bench constants
  // ------------------------------------------------------------
  // identity values are arbitrary
  localparam logic [3:0] T_VER = 4'h3;
  localparam logic [15:0] T_PART = 16'h1c2e;
  localparam logic [10:0] T_MAKER = 11'h155;
  localparam logic [31:0] ID_WORD = {T_VER, T_PART, T_MAKER, jid_pkg::ID_FIXED_BIT0};
  localparam logic [7:0] BSR_CAP = 8'h5a;
  localparam logic [7:0] OFS_CAP = 8'hc3;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] bsr_q = 8'h00;
  logic [7:0] ofs_q = 8'h00;
  jid_pkg::jid_chain_s chain;
  jid_pkg::jid_mode_s mode;
  logic [3:0] instr;
  int err_total = 0;
  int n_checks = 0;
  int n_upd = 0;

  always #5 mclk = ~mclk;

  // external boundary and offset chains, eight cells each
  always @(posedge mclk) begin
    if (chain.capture && mode.bsr_sel) bsr_q <= BSR_CAP;
    else if (chain.shift && mode.bsr_sel) bsr_q <= {chain.serial, bsr_q[7:1]};
    if (chain.capture && (mode.ofs_rd || mode.ofs_wr)) ofs_q <= OFS_CAP;
    else if (chain.shift && (mode.ofs_rd || mode.ofs_wr)) ofs_q <= {chain.serial, ofs_q[7:1]};
    if (chain.update) n_upd++;
  end

  jid_host u_host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  jid_tap_decode #(.ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MAKER(T_MAKER)) uut (
    .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .bsr_so(bsr_q[0]), .ofs_so(ofs_q[0]),
    .chain(chain), .mode(mode), .instr(instr));

  // ------------------------------------------------------------
  // expectations, compare and verdict
  // ------------------------------------------------------------
  function automatic logic [4:0] exp_mode(input logic [3:0] c);
    exp_mode = {c == jid_pkg::IR_EXTEST || c == jid_pkg::IR_CLAMP, c == jid_pkg::IR_HIGHZ,
      c == jid_pkg::IR_EXTEST || c == jid_pkg::IR_SAMPLE, c == jid_pkg::IR_OFS_RD,
      c == jid_pkg::IR_OFS_WR};
  endfunction : exp_mode

  function automatic logic [7:0] exp_dr(input logic [3:0] c, input logic [7:0] d);
    case (c)
      jid_pkg::IR_EXTEST, jid_pkg::IR_SAMPLE: exp_dr = BSR_CAP;
      jid_pkg::IR_DEVICE_IDENTITY_WORD: exp_dr = ID_WORD[7:0];
      jid_pkg::IR_OFS_RD, jid_pkg::IR_OFS_WR: exp_dr = OFS_CAP;
      default: exp_dr = {d[6:0], 1'b0};
    endcase
  endfunction : exp_dr

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // a run needs about 3700 mclk; far beyond that means a hang
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [31:0] got;
    logic [3:0] cap;
    logic [7:0] d;
    logic [4:0] m0;
    int u0;
    d = $urandom(32'hff06e065);
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1 u_host.idle();
    chk("instr", jid_pkg::IR_DEVICE_IDENTITY_WORD, instr);
    u_host.dr_scan(32, $urandom, got);
    chk("id_word", ID_WORD, got);
    chk("tdo_oe", 32'h0000_0000, tdo_oe);
    $display("test reset_identity done");
    // every code, undefined ones included, with random scan data
    for (int c = 0; c < 16; c++) begin
      d = $urandom;
      u_host.ir_load(c[3:0], cap);
      chk("ir_capture", jid_pkg::IR_CAPTURE_VAL, cap);
      chk("instr", c, instr);
      m0 = mode;
      chk("mode", exp_mode(c[3:0]), m0);
      u0 = n_upd;
      u_host.dr_scan(8, d, got);
      chk("dr_out", exp_dr(c[3:0], d), got);
      chk("chain_update", c inside {0, 1, 7, 8}, n_upd - u0);
      chk("mode_hold", m0, mode);
      if (c == 8) chk("ofs_write", d, ofs_q);
    end
    $display("test instruction_table done");
    u_host.trst_pulse();
    chk("instr", jid_pkg::IR_DEVICE_IDENTITY_WORD, instr);
    u_host.dr_scan(32, $urandom, got);
    chk("id_word", ID_WORD, got);
    $display("test pin_reset done");
    u_host.ir_load(jid_pkg::IR_CLAMP, cap);
    u_host.tms_reset();
    chk("instr", jid_pkg::IR_DEVICE_IDENTITY_WORD, instr);
    chk("mode", 32'h0000_0000, mode);
    $display("test tms_reset done");
    complete_run();
  end
endmodule : tb_top
